// ---- common/io_range_cfg.svh ----
// io_range_cfg.svh: offsets, field positions, reset values and decode constants
// assumes: included by the types package and the decoder; definitions only
`ifndef IO_RANGE_CFG_SVH
`define IO_RANGE_CFG_SVH

// register port word indices
`define REG_ADDR_W          3
`define REG_CTRL0_IDX       3'h0
`define REG_BASE0_IDX       3'h1
`define REG_CTRL1_IDX       3'h2
`define REG_BASE1_IDX       3'h3
`define REG_STATUS_IDX      3'h4

// control register fields
`define CTRL_MASK_LO        0
`define CTRL_MASK_HI        4
`define CTRL_MASK_TOP       4
`define CTRL_LATCH_BIT      5
`define CTRL_SLOT_BIT       6
`define CTRL_WIDE_BIT       7

// reset values: general decode with zero base, which keeps the range off
`define CTRL_RESET          8'h00
`define BASE_RESET          8'h00

// shared register access space on the board
`define SHARED_FIRST        12'h0C80
`define SHARED_LAST         12'h0CAF

`endif

// ---- common/io_range_pkg.sv ----
// io_range_pkg: types shared by the range decoder
// assumes: io_range_cfg.svh sits on the include path
package io_range_pkg;
  `include "io_range_cfg.svh"

  localparam int NUM_RANGES = 2;

  // all state of the decoder
  typedef struct packed {
    logic [NUM_RANGES-1:0][7:0] ctrl;   // range_decode_control
    logic [NUM_RANGES-1:0][7:0] base;   // range_base_compare
    logic [NUM_RANGES-1:0]      hold;   // latched match per range
    logic                       cmd_d;  // command strobe one cycle ago
    logic [NUM_RANGES-1:0]      sel_n;
    logic                       wide_n;
    logic                       wide_oe;
    logic                       ldoe;
    logic [7:0]                 rdata;
  } decoder_state_type;
endpackage : io_range_pkg

// ---- rtl/io_range_decoder.sv ----
// io_range_decoder: two programmable i/o address ranges on the system bus
// assumes: bus inputs synchronous to ref_clk_in, registers on a plain strobe port
//
// What this block does
// - two ranges, each control, base, select
// - address enable qualifies every range decode
// - control picks 8- or 32-bit response
// - width indicator is the only bus control
// - optional latch on command, select outlives strobe
// - local data enables only in shared space
// - mask bits drop base bits from compare
// - no mask bits means one doubleword
// - base 5:0 compare address 7:2
// - base 7:6 compare 11:10 or 9:8
// - general decode with zero top disables
// - slot decode needs address 9:8 zero
// - 32-bit match drives select and width low
`timescale 1ns/1ps
`include "io_range_cfg.svh"

module io_range_decoder #(
  parameter int ADDR_W = 12
) (
  input  wire logic                                ref_clk_in,
  input  wire logic                                reset_in,
  // register port
  input  wire logic [`REG_ADDR_W-1:0]              reg_addr_in,
  input  wire logic [7:0]                          reg_wdata_in,
  input  wire logic                                reg_write_in,
  input  wire logic                                reg_read_in,
  output logic      [7:0]                          reg_rdata_out,
  // system bus side
  input  wire logic [ADDR_W-1:0]                   latched_bus_address_in,
  input  wire logic                                aen_in,
  input  wire logic                                cmd_n_in,
  input  wire logic                                bus_write_in,
  output logic                                     wide_slave_indicator_n_out,
  output logic                                     wide_slave_indicator_oe_out,
  // board side
  output logic      [io_range_pkg::NUM_RANGES-1:0] range_select_n_out,
  output logic                                     local_data_out_enable_out
);
  import io_range_pkg::*;

  decoder_state_type st_r;
  decoder_state_type st_nxt;
  logic [NUM_RANGES-1:0] hit;
  logic [NUM_RANGES-1:0] active;

  // compare one range against the bus address
  function automatic logic range_hit(input logic [7:0] ctrl, input logic [7:0] base,
                                     input logic [ADDR_W-1:0] addr);
    logic [5:0] mask;
    logic       low_ok;
    logic       top_ok;
    mask   = {ctrl[`CTRL_MASK_TOP], ctrl[`CTRL_MASK_TOP], ctrl[3:0]};
    low_ok = ((addr[7:2] ^ base[5:0]) & ~mask) == 6'h00;
    if (ctrl[`CTRL_SLOT_BIT]) begin
      top_ok = (addr[11:10] == base[7:6]) && (addr[9:8] == 2'b00);
    end else begin
      top_ok = (addr[9:8] == base[7:6]) && (base[7:6] != 2'b00);
    end
    return low_ok && top_ok;
  endfunction : range_hit

  // address inside the shared register access space
  function automatic logic in_shared(input logic [ADDR_W-1:0] addr);
    return (addr >= `SHARED_FIRST) && (addr <= `SHARED_LAST);
  endfunction : in_shared

  // per-range raw match, qualified by the address enable
  for (genvar i = 0; i < NUM_RANGES; i++) begin : g_hit
    assign hit[i] = !aen_in && range_hit(st_r.ctrl[i], st_r.base[i], latched_bus_address_in);
  end

  // next state: register port, latching and output decode
  always_comb begin
    st_nxt       = st_r;
    st_nxt.cmd_d = cmd_n_in;
    st_nxt.rdata = 8'h00;
    // register writes
    if (reg_write_in) begin
      unique case (reg_addr_in)
        `REG_CTRL0_IDX: st_nxt.ctrl[0] = reg_wdata_in;
        `REG_BASE0_IDX: st_nxt.base[0] = reg_wdata_in;
        `REG_CTRL1_IDX: st_nxt.ctrl[1] = reg_wdata_in;
        `REG_BASE1_IDX: st_nxt.base[1] = reg_wdata_in;
        default:        st_nxt.rdata   = 8'h00;
      endcase
    end
    // register reads, data stand the following cycle only
    if (reg_read_in) begin
      unique case (reg_addr_in)
        `REG_CTRL0_IDX:  st_nxt.rdata = st_r.ctrl[0];
        `REG_BASE0_IDX:  st_nxt.rdata = st_r.base[0];
        `REG_CTRL1_IDX:  st_nxt.rdata = st_r.ctrl[1];
        `REG_BASE1_IDX:  st_nxt.rdata = st_r.base[1];
        `REG_STATUS_IDX: st_nxt.rdata = {2'b00, st_r.ldoe, ~st_r.wide_n, st_r.hold, ~st_r.sel_n};
        default:         st_nxt.rdata = 8'h00;
      endcase
    end
    // latch on command falling edge, keep one cycle past its rise
    for (int i = 0; i < NUM_RANGES; i++) begin
      if (st_r.cmd_d && !cmd_n_in) begin
        st_nxt.hold[i] = hit[i];
      end else if (!cmd_n_in || !st_r.cmd_d) begin
        st_nxt.hold[i] = st_r.hold[i];
      end else begin
        st_nxt.hold[i] = 1'b0;
      end
      active[i]       = st_r.ctrl[i][`CTRL_LATCH_BIT] ? st_nxt.hold[i] : hit[i];
      st_nxt.sel_n[i] = !active[i];
    end
    // width indication is the only bus control driven
    st_nxt.wide_oe = |active;
    st_nxt.wide_n  = 1'b1;
    for (int i = 0; i < NUM_RANGES; i++) begin
      if (active[i] && st_r.ctrl[i][`CTRL_WIDE_BIT]) begin
        st_nxt.wide_n = 1'b0;
      end
    end
    // local data drivers only for system reads of the shared space
    st_nxt.ldoe = (|active) && !bus_write_in && in_shared(latched_bus_address_in);
  end

  // state register
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      st_r.ctrl    <= {NUM_RANGES{`CTRL_RESET}};
      st_r.base    <= {NUM_RANGES{`BASE_RESET}};
      st_r.hold    <= '0;
      st_r.cmd_d   <= 1'b1;
      st_r.sel_n   <= '1;
      st_r.wide_n  <= 1'b1;
      st_r.wide_oe <= 1'b0;
      st_r.ldoe    <= 1'b0;
      st_r.rdata   <= 8'h00;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign reg_rdata_out               = st_r.rdata;
  assign range_select_n_out          = st_r.sel_n;
  assign wide_slave_indicator_n_out  = st_r.wide_n;
  assign wide_slave_indicator_oe_out = st_r.wide_oe;
  assign local_data_out_enable_out   = st_r.ldoe;

  // checks next to the logic
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);

  sequence s_range0_comb;
    !st_r.ctrl[0][`CTRL_LATCH_BIT];
  endsequence

  sequence s_cmd_rise_sel0;
    $rose(cmd_n_in) && !range_select_n_out[0] && st_r.ctrl[0][`CTRL_LATCH_BIT];
  endsequence

  property p_aen_blocks;
    aen_in && (st_nxt.hold == '0) |=> (&range_select_n_out);
  endproperty
  a_aen_blocks: assert property (p_aen_blocks) else $error("select with address enable high");

  property p_wide_match;
    (!range_select_n_out[0] && st_r.ctrl[0][`CTRL_WIDE_BIT] && $stable(st_r.ctrl[0]))
      |-> !wide_slave_indicator_n_out && wide_slave_indicator_oe_out;
  endproperty
  a_wide_match: assert property (p_wide_match) else $error("32-bit range without width low");

  property p_wide_only_on_select;
    wide_slave_indicator_oe_out |-> !(&range_select_n_out);
  endproperty
  a_wide_only_on_select: assert property (p_wide_only_on_select) else $error("width driven w/o select");

  property p_narrow_high;
    (&range_select_n_out) |-> wide_slave_indicator_n_out && !wide_slave_indicator_oe_out;
  endproperty
  a_narrow_high: assert property (p_narrow_high) else $error("width low with no select");

  property p_general_off;
    s_range0_comb ##0 (!st_r.ctrl[0][`CTRL_SLOT_BIT] && st_r.base[0][7:6] == 2'b00) |=> range_select_n_out[0];
  endproperty
  a_general_off: assert property (p_general_off) else $error("disabled general range selected");

  property p_slot_top_zero;
    s_range0_comb ##0 (st_r.ctrl[0][`CTRL_SLOT_BIT] && latched_bus_address_in[9:8] != 2'b00)
      |=> range_select_n_out[0];
  endproperty
  a_slot_top_zero: assert property (p_slot_top_zero) else $error("slot decode with nonzero 9:8");

  property p_low_compare;
    s_range0_comb ##0 (st_r.ctrl[0][4:0] == 5'h00 && latched_bus_address_in[7:2] != st_r.base[0][5:0])
      |=> range_select_n_out[0];
  endproperty
  a_low_compare: assert property (p_low_compare) else $error("unmasked low bits mismatched");

  property p_general_top;
    s_range0_comb ##0 (!st_r.ctrl[0][`CTRL_SLOT_BIT] && latched_bus_address_in[9:8] != st_r.base[0][7:6])
      |=> range_select_n_out[0];
  endproperty
  a_general_top: assert property (p_general_top) else $error("general top bits mismatched");

  property p_latch_hold;
    s_cmd_rise_sel0 ##0 $stable(st_r.ctrl[0]) |=> !range_select_n_out[0];
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched select dropped at strobe rise");

  property p_ldoe_shared;
    local_data_out_enable_out |-> $past(in_shared(latched_bus_address_in)) && !(&range_select_n_out);
  endproperty
  a_ldoe_shared: assert property (p_ldoe_shared) else $error("local enable outside shared space");

  property p_read_one_cycle;
    !reg_read_in |=> reg_rdata_out == 8'h00;
  endproperty
  a_read_one_cycle: assert property (p_read_one_cycle) else $error("read data outside its cycle");

  // range 1 sequences, mirrors of the range 0 ones
  sequence s_range1_comb;
    !st_r.ctrl[1][`CTRL_LATCH_BIT];
  endsequence

  sequence s_cmd_rise_sel1;
    $rose(cmd_n_in) && !range_select_n_out[1] && st_r.ctrl[1][`CTRL_LATCH_BIT];
  endsequence

  // range 1 wide response drives width low with its select
  property p_wide_match1;
    (!range_select_n_out[1] && st_r.ctrl[1][`CTRL_WIDE_BIT] && $stable(st_r.ctrl[1]))
      |-> !wide_slave_indicator_n_out && wide_slave_indicator_oe_out;
  endproperty
  a_wide_match1: assert property (p_wide_match1) else $error("32-bit range 1 without width low");

  // range 1 general decode with zero top stays off
  property p_general_off1;
    s_range1_comb ##0 (!st_r.ctrl[1][`CTRL_SLOT_BIT] && st_r.base[1][7:6] == 2'b00) |=> range_select_n_out[1];
  endproperty
  a_general_off1: assert property (p_general_off1) else $error("disabled general range 1 selected");

  // range 1 slot decode refuses nonzero 9:8
  property p_slot_top_zero1;
    s_range1_comb ##0 (st_r.ctrl[1][`CTRL_SLOT_BIT] && latched_bus_address_in[9:8] != 2'b00)
      |=> range_select_n_out[1];
  endproperty
  a_slot_top_zero1: assert property (p_slot_top_zero1) else $error("range 1 slot decode with nonzero 9:8");

  // range 1 unmasked low bits must all agree
  property p_low_compare1;
    s_range1_comb ##0 (st_r.ctrl[1][4:0] == 5'h00 && latched_bus_address_in[7:2] != st_r.base[1][5:0])
      |=> range_select_n_out[1];
  endproperty
  a_low_compare1: assert property (p_low_compare1) else $error("range 1 low bits mismatched");

  // range 1 general top bits compare 9:8
  property p_general_top1;
    s_range1_comb ##0 (!st_r.ctrl[1][`CTRL_SLOT_BIT] && latched_bus_address_in[9:8] != st_r.base[1][7:6])
      |=> range_select_n_out[1];
  endproperty
  a_general_top1: assert property (p_general_top1) else $error("range 1 general top bits mismatched");

  // range 1 latched select outlives the strobe rise
  property p_latch_hold1;
    s_cmd_rise_sel1 ##0 $stable(st_r.ctrl[1]) |=> !range_select_n_out[1];
  endproperty
  a_latch_hold1: assert property (p_latch_hold1) else $error("range 1 latched select dropped");

  // reset leaves every output negated, checked while reset is high
  property p_reset_quiet;
    @(posedge ref_clk_in) disable iff (1'b0)
      reset_in |=> (&range_select_n_out) && wide_slave_indicator_n_out && !wide_slave_indicator_oe_out
                   && !local_data_out_enable_out && (reg_rdata_out == 8'h00);
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");

  // an exact unmasked slot address selects range 0
  property p_slot_match0;
    s_range0_comb ##0 (st_r.ctrl[0][`CTRL_SLOT_BIT] && !aen_in && st_r.ctrl[0][4:0] == 5'h00
                       && latched_bus_address_in[7:2] == st_r.base[0][5:0]
                       && latched_bus_address_in[11:10] == st_r.base[0][7:6]
                       && latched_bus_address_in[9:8] == 2'b00) |=> !range_select_n_out[0];
  endproperty
  a_slot_match0: assert property (p_slot_match0) else $error("exact slot address not selected");

  // an exact unmasked slot address selects range 1
  property p_slot_match1;
    s_range1_comb ##0 (st_r.ctrl[1][`CTRL_SLOT_BIT] && !aen_in && st_r.ctrl[1][4:0] == 5'h00
                       && latched_bus_address_in[7:2] == st_r.base[1][5:0]
                       && latched_bus_address_in[11:10] == st_r.base[1][7:6]
                       && latched_bus_address_in[9:8] == 2'b00) |=> !range_select_n_out[1];
  endproperty
  a_slot_match1: assert property (p_slot_match1) else $error("exact slot address not selected, range 1");

  // with bit 4 clear, address 7:6 takes part in range 0
  property p_mask_top0;
    s_range0_comb ##0 (!st_r.ctrl[0][`CTRL_MASK_TOP] && latched_bus_address_in[7:6] != st_r.base[0][5:4])
      |=> range_select_n_out[0];
  endproperty
  a_mask_top0: assert property (p_mask_top0) else $error("unmasked 7:6 mismatch selected");

  // with bit 4 clear, address 7:6 takes part in range 1
  property p_mask_top1;
    s_range1_comb ##0 (!st_r.ctrl[1][`CTRL_MASK_TOP] && latched_bus_address_in[7:6] != st_r.base[1][5:4])
      |=> range_select_n_out[1];
  endproperty
  a_mask_top1: assert property (p_mask_top1) else $error("unmasked 7:6 mismatch selected, range 1");

  // a latch capture with address enable high holds nothing
  property p_aen_capture;
    aen_in && st_r.cmd_d && !cmd_n_in |=> st_r.hold == '0;
  endproperty
  a_aen_capture: assert property (p_aen_capture) else $error("capture with address enable high");

  // the latch empties once the strobe has stayed high
  property p_hold_clear;
    st_r.cmd_d && cmd_n_in |=> st_r.hold == '0;
  endproperty
  a_hold_clear: assert property (p_hold_clear) else $error("latched match kept after the strobe");

  // a lone 8-bit range 0 leaves the width high
  property p_narrow_width0;
    (!range_select_n_out[0] && range_select_n_out[1] && !st_r.ctrl[0][`CTRL_WIDE_BIT] && $stable(st_r.ctrl[0]))
      |-> wide_slave_indicator_n_out;
  endproperty
  a_narrow_width0: assert property (p_narrow_width0) else $error("8-bit range 0 drove width low");

  // a lone 8-bit range 1 leaves the width high
  property p_narrow_width1;
    (!range_select_n_out[1] && range_select_n_out[0] && !st_r.ctrl[1][`CTRL_WIDE_BIT] && $stable(st_r.ctrl[1]))
      |-> wide_slave_indicator_n_out;
  endproperty
  a_narrow_width1: assert property (p_narrow_width1) else $error("8-bit range 1 drove width low");

  // local data drivers only ever serve system reads
  property p_ldoe_read;
    local_data_out_enable_out |-> $past(!bus_write_in);
  endproperty
  a_ldoe_read: assert property (p_ldoe_read) else $error("local enable on a system write");

  // neither the width pin nor the local data drivers are enabled without a select
  property p_quiet_bus;
    (&range_select_n_out) |-> !wide_slave_indicator_oe_out && !local_data_out_enable_out;
  endproperty
  a_quiet_bus: assert property (p_quiet_bus) else $error("drivers on with no select");

endmodule : io_range_decoder

// ---- verification/eisa_io_host.sv ----
// eisa_io_host: system bus side that opens and closes i/o cycles
// assumes: bench calls each task just after a rising clock edge
`timescale 1ns/1ps

module eisa_io_host (
  output logic [11:0] address_out,
  output logic        aen_out,
  output logic        cmd_n_out,
  output logic        write_out
);
  // idle bus: no cycle open, address enable high
  initial begin
    address_out = 12'hfff;
    aen_out     = 1'b1;
    cmd_n_out   = 1'b1;
    write_out   = 1'b0;
  end
  // open a cycle; enable low whenever an answer is wanted
  task start(input logic [11:0] a, input logic w, input logic ae);
    address_out <= a;
    aen_out     <= ae;
    write_out   <= w;
    cmd_n_out   <= 1'b0;
  endtask : start
  // address moves on while the command is still low
  task move(input logic [11:0] a);
    address_out <= a;
  endtask : move
  task finish();
    cmd_n_out <= 1'b1;
  endtask : finish
  // released address and write lines show the inverse of their last value, enable goes high
  task idle();
    aen_out     <= 1'b1;
    address_out <= ~address_out;
    write_out   <= ~write_out;
  endtask : idle
endmodule : eisa_io_host

// ---- verification/io_range_decoder_bench.sv ----
// io_range_decoder_bench: directed scenarios for the two i/o decode ranges
// assumes: package and decoder compiled first, io_range_cfg.svh on the include path
`timescale 1ns/1ps
`include "io_range_cfg.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

module io_range_decoder_bench;
  import io_range_pkg::*;
  logic                   clk       = 1'b0;
  logic                   rst       = 1'b1;
  logic [`REG_ADDR_W-1:0] reg_addr  = '0;
  logic [7:0]             reg_wdata = '0;
  logic                   reg_wr_s  = 1'b0;
  logic                   reg_rd_s  = 1'b0;
  logic [7:0]             rdata;
  logic [11:0]            addr;
  logic                   aen, cmd_n, bus_wr, wide_n, wide_oe, ldoe;
  logic [NUM_RANGES-1:0]  sel_n;
  int                     bad_count = 0;
  int                     total_checks = 0;

  // 250 MHz clock
  always #2 clk = ~clk;

  io_range_decoder i_io_range_decoder (.ref_clk_in(clk), .reset_in(rst), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_write_in(reg_wr_s), .reg_read_in(reg_rd_s), .reg_rdata_out(rdata),
    .latched_bus_address_in(addr), .aen_in(aen), .cmd_n_in(cmd_n), .bus_write_in(bus_wr),
    .wide_slave_indicator_n_out(wide_n), .wide_slave_indicator_oe_out(wide_oe),
    .range_select_n_out(sel_n), .local_data_out_enable_out(ldoe));
  eisa_io_host i_eisa_io_host (.address_out(addr), .aen_out(aen), .cmd_n_out(cmd_n), .write_out(bus_wr));

  task stop_test();
    if (bad_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  task reg_wr(input logic [`REG_ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr_s  <= 1'b1;
    @(posedge clk);
    reg_wr_s  <= 1'b0;
  endtask : reg_wr

  // read data stand only in the cycle after the read strobe
  task reg_rd(input logic [`REG_ADDR_W-1:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd_s <= 1'b1;
    @(posedge clk);
    reg_rd_s <= 1'b0;
    #1 `CHK("reg_rdata", e, rdata)
  endtask : reg_rd

  // one non-latched cycle; outputs follow the address one cycle later
  task probe(input logic [11:0] a, input logic w, ae, input logic [1:0] es, input logic ewn, eoe, eld);
    @(posedge clk);
    i_eisa_io_host.start(a, w, ae);
    @(posedge clk);
    #1 `CHK("select_n", es, sel_n)
    `CHK("wide_n", ewn, wide_n)
    `CHK("wide_oe", eoe, wide_oe)
    `CHK("data_oe", eld, ldoe)
    @(posedge clk);
    i_eisa_io_host.finish();
    @(posedge clk);
    i_eisa_io_host.idle();
  endtask : probe

  task test_reset();
    reg_rd(`REG_CTRL0_IDX, 8'h00);
    reg_rd(`REG_BASE1_IDX, 8'h00);
    probe(12'h000, 1'b0, 1'b0, 2'b11, 1'b1, 1'b0, 1'b0);
  endtask : test_reset

  // unmapped write must not land anywhere
  task test_regs();
    reg_wr(`REG_CTRL1_IDX, 8'h3c);
    reg_wr(`REG_BASE1_IDX, 8'hc3);
    reg_wr(3'h5, 8'hff);
    reg_rd(`REG_CTRL1_IDX, 8'h3c);
    reg_rd(`REG_BASE1_IDX, 8'hc3);
    reg_rd(3'h7, 8'h00);
  endtask : test_regs

  // slot decode, 32-bit, window 080..0bf
  task test_slot();
    reg_wr(`REG_CTRL1_IDX, 8'h00);
    reg_wr(`REG_BASE1_IDX, 8'h00);
    reg_wr(`REG_CTRL0_IDX, 8'hcf);
    reg_wr(`REG_BASE0_IDX, 8'h20);
    probe(12'h080, 1'b0, 1'b0, 2'b10, 1'b0, 1'b1, 1'b0);
    probe(12'h0bf, 1'b1, 1'b0, 2'b10, 1'b0, 1'b1, 1'b0);
    probe(12'h0c0, 1'b0, 1'b0, 2'b11, 1'b1, 1'b0, 1'b0);
    probe(12'h180, 1'b0, 1'b0, 2'b11, 1'b1, 1'b0, 1'b0);
    probe(12'h480, 1'b0, 1'b0, 2'b11, 1'b1, 1'b0, 1'b0);
    probe(12'h080, 1'b0, 1'b1, 2'b11, 1'b1, 1'b0, 1'b0);
  endtask : test_slot

  // general decode, 8-bit, one doubleword at 104 and its aliases
  task test_general();
    reg_wr(`REG_CTRL0_IDX, 8'h00);
    reg_wr(`REG_BASE0_IDX, 8'h00);
    reg_wr(`REG_BASE1_IDX, 8'h41);
    probe(12'h104, 1'b0, 1'b0, 2'b01, 1'b1, 1'b1, 1'b0);
    probe(12'h507, 1'b0, 1'b0, 2'b01, 1'b1, 1'b1, 1'b0);
    probe(12'h108, 1'b0, 1'b0, 2'b11, 1'b1, 1'b0, 1'b0);
    reg_wr(`REG_CTRL1_IDX, 8'h10);
    probe(12'h1c4, 1'b0, 1'b0, 2'b01, 1'b1, 1'b1, 1'b0);
    reg_wr(`REG_BASE1_IDX, 8'h01);
    probe(12'h004, 1'b0, 1'b0, 2'b11, 1'b1, 1'b0, 1'b0);
  endtask : test_general

  // latched decode: select outlives a moved address and the command rise
  task test_latch();
    reg_wr(`REG_CTRL0_IDX, 8'hef);
    reg_wr(`REG_BASE0_IDX, 8'h20);
    @(posedge clk);
    i_eisa_io_host.start(12'h080, 1'b0, 1'b0);
    @(posedge clk);
    i_eisa_io_host.move(12'h000);
    @(posedge clk);
    #1 `CHK("select_n", 2'b10, sel_n)
    `CHK("wide_n", 1'b0, wide_n)
    reg_rd(`REG_STATUS_IDX, 8'h15);
    @(posedge clk);
    i_eisa_io_host.finish();
    @(posedge clk);
    #1 `CHK("select_n", 2'b10, sel_n)
    i_eisa_io_host.idle();
    repeat (3) @(posedge clk);
    #1 `CHK("select_n", 2'b11, sel_n)
  endtask : test_latch

  // local data enable only for reads inside the shared space
  task test_shared();
    reg_wr(`REG_CTRL0_IDX, 8'h4f);
    reg_wr(`REG_BASE0_IDX, 8'he0);
    probe(12'hc80, 1'b0, 1'b0, 2'b10, 1'b1, 1'b1, 1'b1);
    probe(12'hcb0, 1'b0, 1'b0, 2'b10, 1'b1, 1'b1, 1'b0);
    probe(12'hc80, 1'b1, 1'b0, 2'b10, 1'b1, 1'b1, 1'b0);
  endtask : test_shared

  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    test_reset();
    test_regs();
    test_slot();
    test_general();
    test_latch();
    test_shared();
    stop_test();
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    stop_test();
  end
endmodule : io_range_decoder_bench
